// ===== inc/tws_pkg.sv
// Constants and types shared by the two-wire serial memory slave.
// Assumes a 50 MHz system clock and a bus clock driven by the master.
package tws_pkg;

  // **********************************************************************
  // Timing
  // **********************************************************************
  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 20;
  // Longest self-timed write, in milliseconds (20 on the lowest grade).
  localparam int WR_TIME_MS = 10;
  // Longest time rounds down to whole cycles.
  localparam int WR_CYCLES = WR_TIME_MS * 1_000_000 / CLK_PERIOD_NS;

  // **********************************************************************
  // Array layout
  // **********************************************************************
  // Word address width: 15 for the larger part, 14 for the smaller.
  localparam int ADDR_W = 15;
  // Bits of the word address that roll over within a page.
  localparam int PAGE_BITS = 6;
  // The locked section spans the top 2**OTP_BITS bytes.
  localparam int OTP_BITS = 8;
  // Bits in one serial word.
  localparam int BYTE_W = 8;
  // Bit counter value of the last data bit and of the ninth clock.
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // Class prefix of the device address word; value is arbitrary.
  localparam logic [4:0] DEV_CLASS = 5'h0d;

  // **********************************************************************
  // Protocol states of the bus engine
  // **********************************************************************
  typedef enum logic [2:0] {
    ST_DEV = 3'h0,
    ST_AHI = 3'h1,
    ST_ALO = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_IGNORE = 3'h5
  } tws_state_t;

endpackage : tws_pkg

// ===== src/tws_mem.sv
// Byte-wide nonvolatile array model of the serial memory.
// Assumes writes are strobed on the rising bus clock edge; reads are
// combinational from the same address.
`timescale 1ns/1ps

module tws_mem #(
  parameter int ADDR_W = tws_pkg::ADDR_W,
  parameter int DATA_W = tws_pkg::BYTE_W
) (
  input wire logic scl,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  // Storage keeps its content across resets, as the real cells do.
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Write port on the sampling edge of the bus clock.
  always_ff @(posedge scl)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  // Read port follows the address directly.
  assign rdata = mem[addr];

endmodule : tws_mem

// ===== src/tws_slave.sv
// Slave protocol engine of a two-wire serial memory with write protect.
// Assumes scl and sda_i come from the bus pins, sda is open drain and
// resolved outside, and the system clock is much faster than scl.
//
// Operation
// R1: SDA falling with SCL high is start.
// R2: SDA rising with SCL high is stop.
// R3: SDA changes only while SCL is low.
// R4: Eight-bit words, device acks on ninth clock.
// R5: Standby at power-up and after stop, idle.
// R6: Master recovers by clocking, then a start.
// R7: Address word: class prefix, two selects, direction.
// R8: Select bits must match the strap pins.
// R9: Eighth address bit high reads, low writes.
// R10: Match acks; mismatch stays silent until start.
// R11: Write-protect pin high blocks every write.
// R12: Byte write: address, two address bytes, data.
// R13: Self-timed write after stop ignores all inputs.
// R14: Page write accepts up to 63 more bytes.
// R15: Write address rolls over within its page.
// R16: Polling acks only once the write ends.
// R17: Locked top 256 bytes reject writes.
// R18: Address counter keeps last address plus one.
// R19: Current read outputs byte at the counter.
// R20: Random read: dummy write, repeated start, read.
// R21: Master ack continues read, wrapping whole array.
// R22: Sample on SCL rise, launch on SCL fall.
// R23: Array of 64-byte pages, 14/15-bit address.
// R24: Address bits above array size are ignored.
`timescale 1ns/1ps

module tws_slave #(
  parameter int ADDR_W = tws_pkg::ADDR_W,
  parameter int WR_CYCLES = tws_pkg::WR_CYCLES,
  parameter logic [4:0] DEV_CLASS = tws_pkg::DEV_CLASS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic cs_hi,
  input wire logic cs_lo,
  input wire logic unused_strap,
  input wire logic wp,
  input wire logic otp_lock,
  output logic standby,
  output logic write_busy
);

  localparam int CW = $clog2(WR_CYCLES + 1);

  // **********************************************************************
  // Functions
  // **********************************************************************
  // Next write address: only the in-page bits advance.
  function automatic logic [ADDR_W-1:0] page_inc(
    input logic [ADDR_W-1:0] a
  );
    logic [tws_pkg::PAGE_BITS-1:0] low;
    low = a[tws_pkg::PAGE_BITS-1:0] + 1'b1;
    page_inc = {a[ADDR_W-1:tws_pkg::PAGE_BITS], low};
  endfunction : page_inc

  // Next read address: the whole counter advances and wraps at the top.
  function automatic logic [ADDR_W-1:0] full_inc(
    input logic [ADDR_W-1:0] a
  );
    full_inc = a + 1'b1;
  endfunction : full_inc

  // **********************************************************************
  // Bus condition detection on the system clock
  // **********************************************************************
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic start_det, stop_det;
  logic lnk_hold_reg, last_start_reg;
  logic wrote_reg, wrote_s1_reg, wrote_s2_reg;
  logic busy_reg, standby_reg, sda_o_reg;
  logic [CW-1:0] wr_cnt_reg;

  // Two-stage synchronisers and one delayed copy for edge detection.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= scl;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
    end
  end

  // R1 R3: start decode
  assign start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  // R2 R3: stop decode
  assign stop_det = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;

  // Holds the bus engine in reset from any stop or start until scl falls
  // after a start, so every frame begins from the address state.
  // R6: recovery by start
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lnk_hold_reg <= 1'b1;
      last_start_reg <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      lnk_hold_reg <= 1'b1;
      last_start_reg <= start_det;
    end
    else if (!scl_s2_reg && last_start_reg)
    begin
      lnk_hold_reg <= 1'b0;
    end
  end

  // Brings the bus-side written flag over as a level.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrote_s1_reg <= 1'b0;
      wrote_s2_reg <= 1'b0;
    end
    else
    begin
      wrote_s1_reg <= wrote_reg;
      wrote_s2_reg <= wrote_s1_reg;
    end
  end

  // Self-timed write: starts at the stop that ends a write sequence.
  // R13: write cycle timer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_reg <= 1'b0;
      wr_cnt_reg <= '0;
    end
    else if (stop_det && wrote_s2_reg)
    begin
      busy_reg <= 1'b1;
      wr_cnt_reg <= CW'(WR_CYCLES - 1);
    end
    else if (busy_reg && wr_cnt_reg == '0)
    begin
      busy_reg <= 1'b0;
    end
    else if (busy_reg)
    begin
      wr_cnt_reg <= wr_cnt_reg - 1'b1;
    end
  end

  // R5: standby when idle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      standby_reg <= 1'b1;
      sda_o_reg <= 1'b0;
    end
    else
    begin
      standby_reg <= !busy_reg && !last_start_reg;
      sda_o_reg <= 1'b0;
    end
  end

  assign standby = standby_reg;
  assign write_busy = busy_reg;
  assign sda_o = sda_o_reg;

  // **********************************************************************
  // Bus engine on the serial clock
  // **********************************************************************
  logic lnk_rst;
  logic [4:0] pin_s1_reg, pin_s2_reg;
  logic cs_lo_s, cs_hi_s, wp_s, otp_s, busy_s;
  tws_pkg::tws_state_t state_reg;
  logic [3:0] bitcnt_reg;
  logic ack_req_reg, tx_active_reg;
  logic [7:0] shreg_reg, txreg_reg, addr_hi_reg, mem_rdata;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] rx_byte;
  logic dev_match, wr_ok, mem_we, rd_load, at_last, at_ack;

  assign lnk_rst = lnk_hold_reg;

  // Straps, protect pins and the busy level cross on the bus clock.
  always_ff @(posedge scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
    end
    else
    begin
      pin_s1_reg <= {busy_reg, otp_lock, wp, cs_hi, cs_lo};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign cs_lo_s = pin_s2_reg[0];
  assign cs_hi_s = pin_s2_reg[1];
  assign wp_s = pin_s2_reg[2];
  assign otp_s = pin_s2_reg[3];
  assign busy_s = pin_s2_reg[4];

  // R22: sample on rise
  assign rx_byte = {shreg_reg[6:0], sda_i};
  assign at_last = bitcnt_reg == tws_pkg::LAST_BIT;
  assign at_ack = bitcnt_reg == tws_pkg::ACK_BIT;
  // R7 R8 R16: class, selects and idle
  assign dev_match = rx_byte[7:3] == DEV_CLASS
    && rx_byte[2:1] == {cs_hi_s, cs_lo_s} && !busy_s;
  // R11 R17: protect checks
  assign wr_ok = !wp_s
    && !(otp_s && &addr_reg[ADDR_W-1:tws_pkg::OTP_BITS]);
  assign mem_we = state_reg == tws_pkg::ST_WDATA && at_last && wr_ok;
  // R21: continue on master ack
  assign rd_load = state_reg == tws_pkg::ST_RDATA && at_ack
    && (!tx_active_reg || !sda_i);

  // Word framing and protocol state for one frame.
  always_ff @(posedge scl or posedge lnk_rst)
  begin
    if (lnk_rst)
    begin
      state_reg <= tws_pkg::ST_DEV;
      bitcnt_reg <= 4'h0;
      ack_req_reg <= 1'b0;
      tx_active_reg <= 1'b0;
    end
    else
    begin
      bitcnt_reg <= at_ack ? 4'h0 : bitcnt_reg + 4'h1;
      if (at_last)
      begin
        // R4: ack each word except read data and ignored words
        ack_req_reg <= state_reg != tws_pkg::ST_RDATA
          && state_reg != tws_pkg::ST_IGNORE;
        case (state_reg)
          tws_pkg::ST_DEV:
          begin
            // R9 R10: direction or silence
            if (!dev_match)
            begin
              ack_req_reg <= 1'b0;
              state_reg <= tws_pkg::ST_IGNORE;
            end
            else if (rx_byte[0])
            begin
              state_reg <= tws_pkg::ST_RDATA;
            end
            else
            begin
              state_reg <= tws_pkg::ST_AHI;
            end
          end
          // R12: address bytes then data
          tws_pkg::ST_AHI: state_reg <= tws_pkg::ST_ALO;
          tws_pkg::ST_ALO: state_reg <= tws_pkg::ST_WDATA;
          // R14: page stays in data
          tws_pkg::ST_WDATA: state_reg <= tws_pkg::ST_WDATA;
          default: state_reg <= state_reg;
        endcase
      end
      else if (at_ack)
      begin
        ack_req_reg <= 1'b0;
        if (rd_load)
        begin
          tx_active_reg <= 1'b1;
        end
        else if (state_reg == tws_pkg::ST_RDATA)
        begin
          state_reg <= tws_pkg::ST_IGNORE;
        end
      end
    end
  end

  // Marks that this frame stored at least one byte.
  always_ff @(posedge scl or posedge lnk_rst)
  begin
    if (lnk_rst)
    begin
      wrote_reg <= 1'b0;
    end
    else if (mem_we)
    begin
      wrote_reg <= 1'b1;
    end
  end

  // Receive shifter for address and data words.
  always_ff @(posedge scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shreg_reg <= 8'h00;
    end
    else if (!at_ack)
    begin
      shreg_reg <= rx_byte;
    end
  end

  // Address counter survives frames; only power-up clears it.
  always_ff @(posedge scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr_hi_reg <= 8'h00;
      addr_reg <= '0;
    end
    else if (state_reg == tws_pkg::ST_AHI && at_last)
    begin
      addr_hi_reg <= rx_byte;
    end
    else if (state_reg == tws_pkg::ST_ALO && at_last)
    begin
      // R20 R23 R24: load, drop high bits
      addr_reg <= ADDR_W'({addr_hi_reg, rx_byte});
    end
    else if (state_reg == tws_pkg::ST_WDATA && at_last)
    begin
      // R15: in-page roll over
      addr_reg <= page_inc(addr_reg);
    end
    else if (rd_load)
    begin
      // R18 R21: last read plus one
      addr_reg <= full_inc(addr_reg);
    end
  end

  // R19: transmit byte at counter
  always_ff @(posedge scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txreg_reg <= 8'h00;
    end
    else if (rd_load)
    begin
      txreg_reg <= mem_rdata;
    end
    else if (state_reg == tws_pkg::ST_RDATA && !at_ack)
    begin
      txreg_reg <= {txreg_reg[6:0], 1'b0};
    end
  end

  // Data line driver, changed only on the falling bus clock.
  // R3 R22: launch on fall
  always_ff @(negedge scl or posedge lnk_rst)
  begin
    if (lnk_rst)
    begin
      sda_oe <= 1'b0;
    end
    else if (state_reg == tws_pkg::ST_RDATA && tx_active_reg && !at_ack)
    begin
      sda_oe <= !txreg_reg[7];
    end
    else if (at_ack)
    begin
      sda_oe <= ack_req_reg;
    end
    else
    begin
      sda_oe <= 1'b0;
    end
  end

  tws_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(tws_pkg::BYTE_W)
  ) u_mem (
    .scl(scl),
    .we(mem_we),
    .addr(addr_reg),
    .wdata(rx_byte),
    .rdata(mem_rdata)
  );

  // **********************************************************************
  // Assertions
  // **********************************************************************
  // A start always puts the engine into reset.
  property p_start_hold;
    @(posedge clk) disable iff (sys_rst)
      start_det |=> lnk_hold_reg && last_start_reg;
  endproperty
  a_start_hold: assert property (p_start_hold) // R1
    else $error("start did not reset the bus engine");

  // A stop resets the engine and marks the bus idle.
  property p_stop_idle;
    @(posedge clk) disable iff (sys_rst)
      stop_det |=> lnk_hold_reg && !last_start_reg ##1 standby_reg == !busy_reg;
  endproperty
  a_stop_idle: assert property (p_stop_idle) // R2
    else $error("stop did not return to idle");

  // The ninth clock of an acknowledged word sees the line pulled low.
  property p_ack_drive;
    @(posedge scl) disable iff (lnk_rst)
      at_ack && ack_req_reg |-> sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) // R4
    else $error("acknowledge not driven in the ninth clock");

  // A foreign address word leaves the device silent.
  property p_nomatch;
    @(posedge scl) disable iff (lnk_rst)
      state_reg == tws_pkg::ST_DEV && at_last && !dev_match
      |=> state_reg == tws_pkg::ST_IGNORE && !ack_req_reg ##1 !sda_oe;
  endproperty
  a_nomatch: assert property (p_nomatch) // R10
    else $error("device answered a foreign address");

  // No array write while the protect pin is high.
  property p_protect;
    @(posedge scl) disable iff (lnk_rst)
      wp_s |-> !mem_we;
  endproperty
  a_protect: assert property (p_protect) // R11
    else $error("write while protected");

  // The locked section is never written while otp_lock is high.
  property p_otp;
    @(posedge scl) disable iff (lnk_rst)
      otp_s && &addr_reg[ADDR_W-1:tws_pkg::OTP_BITS] |-> !mem_we;
  endproperty
  a_otp: assert property (p_otp) // R17
    else $error("write into the locked section");

  // Polling during a write cycle is not acknowledged.
  property p_poll;
    @(posedge scl) disable iff (lnk_rst)
      state_reg == tws_pkg::ST_DEV && at_last && busy_s |=> !ack_req_reg;
  endproperty
  a_poll: assert property (p_poll) // R16
    else $error("acknowledged while the write cycle runs");

  // A data byte keeps the page and advances the in-page bits by one.
  property p_page;
    @(posedge scl) disable iff (lnk_rst)
      state_reg == tws_pkg::ST_WDATA && at_last
      |=> addr_reg[ADDR_W-1:tws_pkg::PAGE_BITS]
        == $past(addr_reg[ADDR_W-1:tws_pkg::PAGE_BITS])
      && addr_reg[tws_pkg::PAGE_BITS-1:0]
        == $past(addr_reg[tws_pkg::PAGE_BITS-1:0]) + 1'b1;
  endproperty
  a_page: assert property (p_page) // R15
    else $error("write address left its page");

  // Each byte read advances the whole counter by one.
  property p_rd_inc;
    @(posedge scl) disable iff (lnk_rst)
      rd_load |=> addr_reg == ADDR_W'($past(addr_reg) + 1'b1);
  endproperty
  a_rd_inc: assert property (p_rd_inc) // R18
    else $error("read counter did not advance");

  // A stop after stored data starts the write cycle and leaves standby.
  property p_wr_cycle;
    @(posedge clk) disable iff (sys_rst)
      stop_det && wrote_s2_reg |=> busy_reg ##1 !standby_reg;
  endproperty
  a_wr_cycle: assert property (p_wr_cycle) // R13
    else $error("write cycle did not start after stop");

  // Scenario coverage.
  c_byte_write: cover property (@(posedge clk) $rose(busy_reg));
  c_seq_read: cover property (@(posedge scl) rd_load && tx_active_reg);
  c_nomatch: cover property (@(posedge scl)
    state_reg == tws_pkg::ST_DEV && at_last && !dev_match);
  c_page_wrap: cover property (@(posedge scl)
    mem_we && &addr_reg[tws_pkg::PAGE_BITS-1:0]);

endmodule : tws_slave

// ===== testbench/tws_master.sv
// Bus master model: drives the bus clock and pulls the data line low.
// Assumes the bench resolves data with a pull-up and runs clk.
`timescale 1ns/1ps

module tws_master (
  input wire logic clk,
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // Quarter bus clock in system cycles; slow stretches the low phase of each bit, not of start or stop.
  localparam int Q = 6;
  int slow = 0;

  // The bus idles with the clock high and data released.
  initial
  begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end

  // Waits for a number of falling system clock edges.
  task automatic wq(input int n);
    repeat (n) @(negedge clk);
  endtask : wq

  task automatic clk_bit(input logic b, output logic g);
    wq(Q + slow);
    sda_pull = ~b;
    wq(Q);
    scl = 1'h1;
    wq(Q);
    g = sda;
    wq(Q);
    scl = 1'h0;
  endtask : clk_bit

  task automatic start();
    wq(Q);
    sda_pull = 1'h0;
    wq(Q);
    scl = 1'h1;
    wq(2 * Q);
    sda_pull = 1'h1;
    wq(2 * Q);
    scl = 1'h0;
  endtask : start

  task automatic stop();
    wq(Q);
    sda_pull = 1'h1;
    wq(Q);
    scl = 1'h1;
    wq(2 * Q);
    sda_pull = 1'h0;
    wq(2 * Q);
  endtask : stop

  task automatic send(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], g);
    clk_bit(1'h1, g);
    ack = ~g;
  endtask : send

  task automatic recv(input logic more, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'h1, g);
      d[i] = g;
    end
    clk_bit(~more, g);
  endtask : recv

  task automatic recover();
    // Releases data first, so that only the device can hold it low.
    wq(Q);
    sda_pull = 1'h0;
    for (int i = 0; i < 9; i++)
    begin
      wq(2 * Q);
      scl = 1'h1;
      wq(Q);
      if (sda === 1'h1)
        break;
      wq(Q);
      scl = 1'h0;
    end
    sda_pull = 1'h1;
    wq(2 * Q);
    scl = 1'h0;
    stop();
  endtask : recover
endmodule : tws_master

// ===== testbench/testbench.sv
// Self-checking bench for the two-wire serial memory slave.
// Assumes the master model owns the bus clock; data has a pull-up.
`timescale 1ns/1ps

module testbench;
  // ****************************************************************
  // Bench state and checks
  // ****************************************************************
  localparam int AW = tws_pkg::ADDR_W;
  localparam int WRC = 400;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic cs_hi = 1'h0;
  logic cs_lo = 1'h0;
  logic strap = 1'h0;
  logic wp = 1'h0;
  logic lock = 1'h0;
  logic scl, sda_pull, sda, sda_o, sda_oe, standby, write_busy;
  logic [7:0] mem [0:(1 << AW) - 1];
  logic [AW-1:0] cnt;
  int seed = 81178;
  int mismatches = 0;
  int checks_done = 0;

  // Data is high unless the master or the device pulls it low.
  assign sda = ~sda_pull & ~(sda_oe & ~sda_o);

  // The system clock toggles every half period.
  always #10 clk = ~clk;

  tws_slave #(.WR_CYCLES(WRC)) i_tws_slave (
    .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .cs_hi(cs_hi), .cs_lo(cs_lo),
    .unused_strap(strap), .wp(wp), .otp_lock(lock),
    .standby(standby), .write_busy(write_busy)
  );
  tws_master i_tws_master (
    .clk(clk), .scl(scl), .sda_pull(sda_pull), .sda(sda)
  );

  task automatic finish_test();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk_bit(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  // Builds the device word from the current strap levels.
  function automatic logic [7:0] dev(input logic rw);
    return {tws_pkg::DEV_CLASS, cs_hi, cs_lo, rw};
  endfunction : dev

  // A frame that the device must leave unanswered.
  task automatic nack(input logic [7:0] v);
    logic a;
    i_tws_master.start();
    i_tws_master.send(v, a);
    chk_bit(a, 1'h0, "unexpected ack");
    i_tws_master.stop();
  endtask : nack

  // Writes n random bytes and tracks what the array should hold.
  task automatic wr(input logic [15:0] w, input int n);
    logic a;
    logic hit;
    logic [7:0] d;
    logic [AW-1:0] p;
    hit = 1'h0;
    p = w[AW-1:0];
    i_tws_master.start();
    i_tws_master.send(dev(1'h0), a);
    chk_bit(a, 1'h1, "device word ack");
    i_tws_master.send(w[15:8], a);
    chk_bit(a, 1'h1, "high address ack");
    i_tws_master.send(w[7:0], a);
    chk_bit(a, 1'h1, "low address ack");
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      i_tws_master.send(d, a);
      chk_bit(a, 1'h1, "data ack");
      if (!wp && !(lock && &p[AW-1:8]))
      begin
        mem[p] = d;
        hit = 1'h1;
      end
      p[5:0] = p[5:0] + 6'h01;
    end
    i_tws_master.stop();
    chk_bit(write_busy, hit, "busy after stop");
    chk_bit(standby, ~hit, "standby after stop");
    if (hit)
    begin
      nack(dev(1'h0));
      for (int i = 0; i < WRC + 50 && write_busy === 1'h1; i++)
        @(negedge clk);
      repeat (3) @(negedge clk);
      chk_bit(write_busy, 1'h0, "write cycle end");
      chk_bit(standby, 1'h1, "standby after write");
    end
  endtask : wr

  // Reads n bytes, from w when rnd is set, else from the counter.
  task automatic rd(input logic [15:0] w, input int n, input logic rnd);
    logic a;
    logic [7:0] d;
    if (rnd)
    begin
      i_tws_master.start();
      i_tws_master.send(dev(1'h0), a);
      chk_bit(a, 1'h1, "dummy write ack");
      i_tws_master.send(w[15:8], a);
      i_tws_master.send(w[7:0], a);
      chk_bit(a, 1'h1, "address ack");
      cnt = w[AW-1:0];
    end
    i_tws_master.start();
    i_tws_master.send(dev(1'h1), a);
    chk_bit(a, 1'h1, "read word ack");
    for (int i = 0; i < n; i++)
    begin
      i_tws_master.recv(i < n - 1, d);
      chk_byte(d, mem[cnt]);
      cnt++;
    end
    i_tws_master.stop();
    chk_bit(standby, 1'h1, "standby after read");
  endtask : rd

  // Main sequence: random frames first, then the corner cases.
  initial
  begin
    logic a;
    logic [7:0] d;
    logic [15:0] w;
    logic [15:0] base;
    int n;
    repeat (20) @(negedge clk);
    sys_rst = 1'h0;
    chk_bit(standby, 1'h1, "standby after reset");
    repeat (5) @(negedge clk);
    for (int k = 0; k < 4; k++)
    begin
      cs_hi = 1'($random(seed));
      cs_lo = 1'($random(seed));
      strap = 1'($random(seed));
      i_tws_master.slow = $random(seed) & 3;
      w = 16'($random(seed));
      w[3:0] = 4'h0;
      n = 1 + ($random(seed) & 3);
      wr(w, n);
      rd(w, n, 1'h1);
    end
    nack(dev(1'h0) ^ 8'h04);
    nack(dev(1'h1) ^ 8'h02);
    nack(dev(1'h0) ^ 8'h80);
    chk_bit(standby, 1'h1, "standby after mismatch");
    i_tws_master.slow = 0;
    base = {2'h0, 8'($random(seed)), 6'h00};
    wr(base | 16'h003c, 66);
    rd(base, 64, 1'h1);
    wr(16'h7fff, 1);
    wr(16'h0000, 2);
    rd(16'h7fff, 2, 1'h1);
    rd(16'h0000, 1, 1'h0);
    wp = 1'h1;
    wr(base | 16'h0005, 1);
    wp = 1'h0;
    rd(base | 16'h0005, 1, 1'h1);
    lock = 1'h1;
    wr(16'hffff, 1);
    wr(base, 1);
    lock = 1'h0;
    rd(16'h7fff, 1, 1'h1);
    rd(base, 3, 1'h1);
    i_tws_master.start();
    i_tws_master.send(dev(1'h1), a);
    i_tws_master.recv(1'h1, d);
    chk_byte(d, mem[cnt]);
    i_tws_master.recover();
    rd(base | 16'h0010, 2, 1'h1);
    finish_test();
  end

  // Cuts a hung run short well after the expected end.
  initial
  begin
    #2_000_000;
    mismatches++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end
endmodule : testbench
